/* hw/mmad_pkg.sv */
// Package of constants and types for the memory map access decoder.
package mmad_pkg;
    // ----------------------------------------------------------------
    // Address layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam int ADDR_TOP_BIT = 10;
    localparam int LEVEL_BIT = 6;
    localparam logic [1:0] UPPER_NV_CODE = 2'h2;
    localparam logic [1:0] REG_AREA_CODE = 2'h3;
    localparam logic [7:0] APP_BLK_ALL = 8'hff;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [10:0] SYS_MIRROR_LO = 11'h600;
    localparam logic [10:0] SYS_MIRROR_HI = 11'h63f;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MMAD_LVL_APP = 2'h0,
        MMAD_LVL_MEAS = 2'h1,
        MMAD_LVL_SYS = 2'h2,
        MMAD_LVL_FACT = 2'h3
    } mmad_level_e;

    typedef enum logic {
        MMAD_TGT_NV = 1'b0,
        MMAD_TGT_REG = 1'b1
    } mmad_target_e;

    typedef enum logic [2:0] {
        MMAD_ST_IDLE = 3'b001,
        MMAD_ST_GRANT = 3'b010,
        MMAD_ST_DENY = 3'b100
    } mmad_state_e;
endpackage : mmad_pkg

/* hw/mmad_decode.sv */
// Combinational address decoder for target and access level.
`timescale 1ns/10ps
`default_nettype none
module mmad_decode (
    // Request
    input wire logic [mmad_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_application_block_count,
    // Decode
    output mmad_pkg::mmad_target_e o_target,
    output mmad_pkg::mmad_level_e o_level,
    output logic [mmad_pkg::ADDR_W-1:0] o_eff_addr
);
    import mmad_pkg::*;

    logic [9:0] app_end;

    always_comb begin
        app_end = {i_application_block_count, 2'h3};
        o_target = MMAD_TGT_NV;
        o_level = MMAD_LVL_APP;
        o_eff_addr = i_addr;
        if (!i_addr[ADDR_TOP_BIT]) begin
            if (i_application_block_count == APP_BLK_ALL) begin
                o_level = MMAD_LVL_APP;
            end else if (i_addr[9:0] <= app_end) begin
                o_level = MMAD_LVL_APP;
            end else begin
                o_level = MMAD_LVL_MEAS;
            end
        end else if (i_addr[10:9] == UPPER_NV_CODE) begin
            o_eff_addr = {i_addr[10:9], 2'h0, i_addr[6:0]};
            o_level = i_addr[LEVEL_BIT] ? MMAD_LVL_FACT : MMAD_LVL_SYS;
        end else begin
            o_target = MMAD_TGT_REG;
            o_eff_addr = {i_addr[10:8], 1'b0, i_addr[6:0]};
            o_level = i_addr[LEVEL_BIT] ? MMAD_LVL_FACT : MMAD_LVL_SYS;
        end
    end
endmodule : mmad_decode
`default_nettype wire

/* hw/mmad_checker.sv */
// Access checker that grants or refuses reader and host requests.
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Behaviour
// ----------------------------------------------------------------
module mmad_checker (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Request
    input wire logic i_req,
    input wire logic i_is_host,
    input wire logic i_write,
    input wire logic i_lock_cmd,
    input wire logic [mmad_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_application_block_count,
    // Access rights granted so far
    input wire logic i_app_access,
    input wire logic i_meas_access,
    input wire logic i_sys_access,
    input wire logic i_fact_access,
    // Answer
    output logic o_done,
    output logic o_grant,
    output logic o_pwd_err,
    output logic o_read_zero,
    output logic o_target,
    output logic [1:0] o_level,
    output logic [mmad_pkg::ADDR_W-1:0] o_eff_addr
);
    import mmad_pkg::*;

    mmad_target_e dec_target;
    mmad_level_e dec_level;
    logic [ADDR_W-1:0] dec_addr;

    mmad_state_e state_q, state_d;
    logic grant_d;
    logic err_d, err_q;
    logic zero_d, zero_q;
    logic done_d, done_q;
    logic target_q;
    logic [1:0] level_q;
    logic [ADDR_W-1:0] eff_q;
    logic wr_ok;
    logic mirror;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Kept combinational so the check settles in the request cycle.
    mmad_decode u_decode (
        .i_addr(i_addr),
        .i_application_block_count(i_application_block_count),
        .o_target(dec_target),
        .o_level(dec_level),
        .o_eff_addr(dec_addr)
    );

    function automatic logic reader_may_write(input mmad_level_e lvl, input logic app,
                                              input logic meas, input logic sys);
        case (lvl)
            MMAD_LVL_APP: reader_may_write = app;
            MMAD_LVL_MEAS: reader_may_write = meas;
            MMAD_LVL_SYS: reader_may_write = sys;
            default: reader_may_write = 1'b0;
        endcase
    endfunction : reader_may_write

    // ----------------------------------------------------------------
    // Check
    // ----------------------------------------------------------------
    always_comb begin
        mirror = (dec_addr >= SYS_MIRROR_LO) && (dec_addr <= SYS_MIRROR_HI);
        wr_ok = 1'b0;
        grant_d = 1'b0;
        err_d = 1'b0;
        zero_d = 1'b0;
        done_d = i_req;
        state_d = MMAD_ST_IDLE;
        if (i_req) begin
            if (i_is_host) begin
                if (i_write) begin
                    wr_ok = (dec_level != MMAD_LVL_FACT) || i_fact_access;
                end else begin
                    wr_ok = 1'b1;
                    zero_d = mirror || (dec_target == MMAD_TGT_REG
                                        && dec_level == MMAD_LVL_FACT);
                end
            end else if (i_write) begin
                if (dec_level == MMAD_LVL_FACT) begin
                    wr_ok = i_lock_cmd;
                    err_d = !i_lock_cmd;
                end else begin
                    wr_ok = reader_may_write(dec_level, i_app_access,
                                             i_meas_access, i_sys_access);
                end
            end else begin
                wr_ok = 1'b1;
                zero_d = (dec_level == MMAD_LVL_FACT) || mirror;
            end
            grant_d = wr_ok && !zero_d;
            state_d = grant_d ? MMAD_ST_GRANT : MMAD_ST_DENY;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_q <= MMAD_ST_IDLE;
            err_q <= 1'b0;
            zero_q <= 1'b0;
            done_q <= 1'b0;
            target_q <= 1'b0;
            level_q <= 2'h0;
            eff_q <= '0;
        end else begin
            state_q <= state_d;
            err_q <= err_d;
            zero_q <= zero_d;
            done_q <= done_d;
            target_q <= dec_target;
            level_q <= dec_level;
            eff_q <= dec_addr;
        end
    end

    assign o_done = done_q;
    // The one-hot grant bit of the state doubles as the grant flop, so no copy is kept.
    assign o_grant = state_q[1];
    assign o_pwd_err = err_q;
    assign o_read_zero = zero_q;
    assign o_target = target_q;
    assign o_level = level_q;
    assign o_eff_addr = eff_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_reader_fact_write_err;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req && !i_is_host && i_write && !i_lock_cmd && i_addr[10] && i_addr[6])
            |=> (o_pwd_err && !o_grant);
    endproperty
    a_reader_fact_write_err: assert property (p_reader_fact_write_err)
        else $error("Reader factory write did not raise an error.");

    property p_host_fact_drop;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req && i_is_host && i_write && !i_fact_access && i_addr[10] && i_addr[6])
            |=> (!o_grant && !o_pwd_err);
    endproperty
    a_host_fact_drop: assert property (p_host_fact_drop)
        else $error("Host factory write was not silently dropped.");

    property p_mirror_read_zero;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req && !i_write && i_addr[10:9] == REG_AREA_CODE && !i_addr[8] && !i_addr[6])
            |=> (o_read_zero && !o_pwd_err);
    endproperty
    a_mirror_read_zero: assert property (p_mirror_read_zero)
        else $error("System mirror read did not return zero.");

    property p_upper_alias;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req && i_addr[10:9] == UPPER_NV_CODE) |=> (o_eff_addr[8:7] == 2'h0 && !o_target);
    endproperty
    a_upper_alias: assert property (p_upper_alias)
        else $error("Upper array alias bits not cleared.");

    property p_reg_area;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req && i_addr[10:9] == REG_AREA_CODE)
            |=> (o_target && !o_eff_addr[7] && o_level[1] && o_level[0] == $past(i_addr[6]));
    endproperty
    a_reg_area: assert property (p_reg_area)
        else $error("Register area decode wrong.");

    property p_no_meas_full;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req && !i_addr[10] && i_application_block_count == APP_BLK_ALL)
            |=> (o_level == 2'h0);
    endproperty
    a_no_meas_full: assert property (p_no_meas_full)
        else $error("Measurement region present with full block count.");

    property p_reader_read_ok;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req && !i_is_host && !i_write && !i_addr[10]) |=> o_grant;
    endproperty
    a_reader_read_ok: assert property (p_reader_read_ok)
        else $error("Reader read of lower array refused.");

    property p_meas_write_needs_grant;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req && !i_is_host && i_write && !i_addr[10] && !i_meas_access && !i_app_access)
            |=> !o_grant;
    endproperty
    a_meas_write_needs_grant: assert property (p_meas_write_needs_grant)
        else $error("Reader lower write granted without access.");
endmodule : mmad_checker
`default_nettype wire

/* dv/mmad_req_model.sv */
// Request source model standing in for the reader and host command paths.
`timescale 1ns/10ps
`default_nettype none
module mmad_req_model (
    // Clock
    input wire logic i_ref_clk,
    // Request
    output logic o_req,
    output logic o_is_host,
    output logic o_write,
    output logic o_lock_cmd,
    output logic [mmad_pkg::ADDR_W-1:0] o_addr
);
    initial begin
        o_req <= 1'b0;
        {o_is_host, o_write, o_lock_cmd, o_addr} <= 14'h0;
    end

    // Called just after a rising edge; the request is taken at the next one.
    // Released qualifiers are inverted so a stale value can never look valid.
    task automatic access(input logic [2:0] hwl, input logic [10:0] addr, input logic last);
        begin
            o_req <= 1'b1;
            {o_is_host, o_write, o_lock_cmd, o_addr} <= {hwl, addr};
            @(posedge i_ref_clk);
            if (last) begin
                o_req <= 1'b0;
                {o_is_host, o_write, o_lock_cmd, o_addr} <= ~{hwl, addr};
            end
        end
    endtask : access
endmodule : mmad_req_model
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the memory map access decoder.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import mmad_pkg::*;
    // Flags: hwl is {host, write, lock}; acc is {fact, sys, meas, app};
    // expected flags are {grant, pwd_err, read_zero, target}.
    typedef struct packed {
        logic [2:0] hwl;
        logic [10:0] addr;
        logic [7:0] blk;
        logic [3:0] acc;
        logic [3:0] flags;
        logic [1:0] lvl;
        logic [10:0] eff;
    } mmad_row_s;
    localparam mmad_row_s ROWS [18] = '{
        '{3'h0, 11'h000, 8'h0f, 4'h0, 4'h8, 2'h0, 11'h000},
        '{3'h2, 11'h03f, 8'h0f, 4'he, 4'h0, 2'h0, 11'h03f},
        '{3'h2, 11'h03f, 8'h0f, 4'h1, 4'h8, 2'h0, 11'h03f},
        '{3'h2, 11'h040, 8'h0f, 4'hd, 4'h0, 2'h1, 11'h040},
        '{3'h2, 11'h040, 8'h0f, 4'h2, 4'h8, 2'h1, 11'h040},
        '{3'h6, 11'h3ff, 8'h0f, 4'h0, 4'h8, 2'h1, 11'h3ff},
        '{3'h0, 11'h3ff, 8'hff, 4'h0, 4'h8, 2'h0, 11'h3ff},
        '{3'h2, 11'h585, 8'h0f, 4'hb, 4'h0, 2'h2, 11'h405},
        '{3'h2, 11'h585, 8'h0f, 4'h4, 4'h8, 2'h2, 11'h405},
        '{3'h0, 11'h4c0, 8'h0f, 4'hf, 4'h2, 2'h3, 11'h440},
        '{3'h2, 11'h440, 8'h0f, 4'hf, 4'h4, 2'h3, 11'h440},
        '{3'h3, 11'h440, 8'h0f, 4'h0, 4'h8, 2'h3, 11'h440},
        '{3'h6, 11'h440, 8'h0f, 4'h7, 4'h0, 2'h3, 11'h440},
        '{3'h6, 11'h440, 8'h0f, 4'h8, 4'h8, 2'h3, 11'h440},
        '{3'h4, 11'h440, 8'h0f, 4'h0, 4'h8, 2'h3, 11'h440},
        '{3'h0, 11'h680, 8'h0f, 4'hf, 4'h3, 2'h2, 11'h600},
        '{3'h6, 11'h610, 8'h0f, 4'h0, 4'h9, 2'h2, 11'h610},
        '{3'h4, 11'h7c0, 8'h0f, 4'h0, 4'h3, 2'h3, 11'h740}
    };
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] blk = 8'h0;
    logic [3:0] acc = 4'h0;
    logic req, host, wr, lock, done, grant, perr, rz, tgt;
    logic [1:0] lvl;
    logic [10:0] addr, eff;
    int num_errors = 0;
    int compares = 0;
    int ndone = 0;
    int n0;

    mmad_req_model req_m (.i_ref_clk(clk), .o_req(req), .o_is_host(host), .o_write(wr),
        .o_lock_cmd(lock), .o_addr(addr));
    mmad_checker dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_req(req), .i_is_host(host),
        .i_write(wr), .i_lock_cmd(lock), .i_addr(addr), .i_application_block_count(blk),
        .i_app_access(acc[0]), .i_meas_access(acc[1]), .i_sys_access(acc[2]),
        .i_fact_access(acc[3]), .o_done(done), .o_grant(grant), .o_pwd_err(perr),
        .o_read_zero(rz), .o_target(tgt), .o_level(lvl), .o_eff_addr(eff));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (done === 1'b1) begin
            ndone <= ndone + 1;
        end
    end

    task automatic print_verdict;
        begin
            $display("compares=%0d num_errors=%0d", compares, num_errors);
            if (num_errors == 0 && compares > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask : print_verdict

    // The whole run is under a hundred cycles, so this only catches a hang.
    initial begin
        repeat (500) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK({done, grant, perr, rz, tgt, lvl, eff}, 17'h0)
        $display("test reset done");
        // ----------------------------------------------------------------
        // Ordinary cases
        // ----------------------------------------------------------------
        for (int i = 0; i < 18; i++) begin
            @(posedge clk);
            blk <= ROWS[i].blk;
            acc <= ROWS[i].acc;
            req_m.access(ROWS[i].hwl, ROWS[i].addr, 1'b1);
            #1;
            `CHK(done, 1'b1)
            `CHK({grant, perr, rz, tgt}, ROWS[i].flags)
            `CHK({lvl, eff}, {ROWS[i].lvl, ROWS[i].eff})
            $display("test row %0d done", i);
        end
        // ----------------------------------------------------------------
        // Back-to-back requests and reset in mid-run
        // ----------------------------------------------------------------
        // Two edges let the last row's done be counted before the snapshot.
        repeat (2) @(posedge clk);
        acc <= 4'h0;
        blk <= 8'hff;
        n0 = ndone;
        req_m.access(3'h2, 11'h000, 1'b0);
        req_m.access(3'h2, 11'h3fc, 1'b1);
        #1;
        `CHK({done, grant, lvl, eff}, {1'b1, 1'b0, 2'h0, 11'h3fc})
        @(posedge clk);
        #1;
        `CHK(ndone - n0, 2)
        $display("test back_to_back done");
        @(posedge clk);
        rst <= 1'b1;
        req_m.access(3'h4, 11'h440, 1'b1);
        #1;
        `CHK({done, grant, lvl, eff}, 15'h0)
        @(posedge clk);
        rst <= 1'b0;
        req_m.access(3'h4, 11'h63f, 1'b1);
        #1;
        `CHK({done, grant, perr, rz, tgt, lvl, eff}, {1'b1, 4'h3, 2'h2, 11'h63f})
        $display("test mid_reset done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
